// File: src/caf_pkg.sv
// package of constants and carrier types for the can acceptance filter
package caf_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int NUM_MB    = 32;
    localparam int NUM_MASK  = 8;
    localparam int IDX_W     = 5;
    localparam int FIFO_BASE = 24;
    localparam int FIFO_MK0  = 6;
    localparam int FIFO_MK1  = 7;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_MINV   = 12'h004;
    localparam logic [11:0] OFF_RXEN   = 12'h008;
    localparam logic [11:0] OFF_STAT   = 12'h00C;
    localparam logic [11:0] OFF_FIFO0  = 12'h010;
    localparam logic [11:0] OFF_FIFO1  = 12'h014;
    localparam logic [11:0] OFF_MASK   = 12'h020;
    localparam logic [11:0] OFF_MASK_E = 12'h03C;
    localparam logic [11:0] OFF_MB     = 12'h100;
    localparam logic [11:0] OFF_MB_E   = 12'h17C;
    // ****************************************
    // field layout of the control word and of an id / mask word
    // ****************************************
    localparam int CTRL_FMT_LSB  = 0;
    localparam int CTRL_FIFO_BIT = 2;
    localparam int IDE_BIT       = 31;
    localparam int RTR_BIT       = 30;
    localparam logic [31:0] LEGAL_BITS = 32'hDFFF_FFFF;
    localparam logic [31:0] EXT_BITS   = 32'h0003_FFFF;
    localparam logic [1:0]  FMT_MIXED  = 2'b10;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  RST_FMT  = 2'b00;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic        valid;
        logic [31:0] id;
    } caf_rx_t;
    typedef struct packed {
        logic             store;
        logic             discard;
        logic             to_fifo;
        logic [IDX_W-1:0] index;
    } caf_res_t;
endpackage : caf_pkg

// File: src/caf_filter.sv
// acceptance filter with apb register file
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module caf_filter
    import caf_pkg::*;
#(
    parameter int MBS   = NUM_MB,
    parameter int MASKS = NUM_MASK
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire caf_rx_t     rx_frame,
    output var  caf_res_t    result
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0]                fmt;
        logic                      fifo_mode;
        logic [MBS-1:0]            mask_inval;
        logic [MBS-1:0]            rx_en;
        logic [1:0][31:0]          fifo_cmp;
        logic [MASKS-1:0][31:0]    mask;
        logic [MBS-1:0][31:0]      mb_id;
        logic [31:0]               rdata;
        logic                      ready;
        logic                      slverr;
        caf_res_t                  res;
        logic                      last_hit;
        logic                      last_fifo;
        logic [IDX_W-1:0]          last_idx;
    } caf_state_t;

    caf_state_t s;
    caf_state_t next_s;

    localparam int PER_MASK = MBS / MASKS;

    // ****************************************
    // compare
    // ****************************************
    function automatic logic caf_match(
        input logic [31:0] rx,
        input logic [31:0] id,
        input logic [31:0] mask,
        input logic        inval,
        input logic        mixed
    );
        logic [31:0] eff;
        eff = inval ? LEGAL_BITS : (mask & LEGAL_BITS);
        if (!mixed) begin
            eff[IDE_BIT] = 1'b0;
        end
        if (!rx[IDE_BIT]) begin
            eff = eff & ~EXT_BITS;
        end
        return ((rx ^ id) & eff) == RST_WORD;
    endfunction : caf_match

    logic [MBS-1:0] hit_mb;
    logic           mixed;
    logic           fifo_hit;

    assign mixed = (s.fmt == FMT_MIXED);

    genvar g;
    generate
        for (g = 0; g < MBS; g++) begin : g_mb
            // mailboxes at and above the fifo base belong to the fifo in fifo mode
            assign hit_mb[g] = s.rx_en[g]
                               && !(s.fifo_mode && g >= FIFO_BASE)
                               && caf_match(rx_frame.id, s.mb_id[g], s.mask[g / PER_MASK],
                                            s.mask_inval[g], mixed);
        end
    endgenerate

    // fifo filters ignore the mailbox ids entirely
    assign fifo_hit = s.fifo_mode
        && (caf_match(rx_frame.id, s.fifo_cmp[0], s.mask[FIFO_MK0], 1'b0, mixed)
         || caf_match(rx_frame.id, s.fifo_cmp[1], s.mask[FIFO_MK1], 1'b0, mixed));

    // ****************************************
    // next state
    // ****************************************
    logic        acc;
    logic        wr_now;
    logic        in_mask;
    logic        in_mb;
    logic [31:0] rd;
    logic        bad;

    always_comb begin
        next_s  = s;
        acc     = psel && penable;
        wr_now  = acc && s.ready && pwrite;
        in_mask = (paddr >= OFF_MASK) && (paddr <= OFF_MASK_E);
        in_mb   = (paddr >= OFF_MB) && (paddr <= OFF_MB_E);
        rd      = RST_WORD;
        bad     = 1'b0;
        // one wait state keeps every bus output on a flop
        unique case (paddr)
            OFF_CTRL: begin
                rd[CTRL_FMT_LSB +: 2] = s.fmt;
                rd[CTRL_FIFO_BIT]     = s.fifo_mode;
            end
            OFF_MINV: begin
                rd = 32'(s.mask_inval);
            end
            OFF_RXEN: begin
                rd = 32'(s.rx_en);
            end
            OFF_STAT: begin
                rd[IDX_W-1:0] = s.last_idx;
                rd[8]         = s.last_fifo;
                rd[9]         = s.last_hit;
            end
            OFF_FIFO0: begin
                rd = s.fifo_cmp[0];
            end
            OFF_FIFO1: begin
                rd = s.fifo_cmp[1];
            end
            default: begin
                if (in_mask) begin
                    rd = s.mask[paddr[4:2]];
                end else if (in_mb) begin
                    rd = s.mb_id[paddr[6:2]];
                end else begin
                    bad = 1'b1;
                end
            end
        endcase
        next_s.ready  = acc && !s.ready;
        next_s.rdata  = (acc && !s.ready && !pwrite && !bad) ? rd : RST_WORD;
        next_s.slverr = acc && !s.ready && bad;
        if (wr_now) begin
            unique case (paddr)
                OFF_CTRL: begin
                    next_s.fmt       = pwdata[CTRL_FMT_LSB +: 2];
                    next_s.fifo_mode = pwdata[CTRL_FIFO_BIT];
                end
                OFF_MINV: begin
                    next_s.mask_inval = pwdata[MBS-1:0];
                end
                OFF_RXEN: begin
                    next_s.rx_en = pwdata[MBS-1:0];
                end
                OFF_FIFO0: begin
                    next_s.fifo_cmp[0] = pwdata & LEGAL_BITS;
                end
                OFF_FIFO1: begin
                    next_s.fifo_cmp[1] = pwdata & LEGAL_BITS;
                end
                default: begin
                    if (in_mask) begin
                        next_s.mask[paddr[4:2]] = pwdata & LEGAL_BITS;
                    end else if (in_mb) begin
                        // ide stays as written; software keeps it 0 outside mixed mode
                        next_s.mb_id[paddr[6:2]] = pwdata & LEGAL_BITS;
                    end
                end
            endcase
        end
        // frame decision: one pulse per received frame, lowest mailbox wins
        next_s.res = '0;
        if (rx_frame.valid) begin
            if (hit_mb != '0) begin
                next_s.res.store = 1'b1;
                for (int i = MBS - 1; i >= 0; i--) begin
                    if (hit_mb[i]) begin
                        next_s.res.index = IDX_W'(i);
                    end
                end
            end else if (fifo_hit) begin
                next_s.res.store   = 1'b1;
                next_s.res.to_fifo = 1'b1;
                next_s.res.index   = IDX_W'(FIFO_BASE);
            end else begin
                next_s.res.discard = 1'b1;
            end
            next_s.last_hit  = next_s.res.store;
            next_s.last_fifo = next_s.res.to_fifo;
            next_s.last_idx  = next_s.res.index;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s     <= '0;
            s.fmt <= RST_FMT;
        end else begin
            s <= next_s;
        end
    end

    assign prdata  = s.rdata;
    assign pready  = s.ready;
    assign pslverr = s.slverr;
    assign result  = s.res;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    bus_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    one_verdict_a: assert property (!(result.store && result.discard))
        else $error("frame both stored and discarded");
    verdict_each_a: assert property (rx_frame.valid |=> (result.store ^ result.discard))
        else $error("received frame got no verdict");
    no_frame_a: assert property (!rx_frame.valid |=> !result.store && !result.discard)
        else $error("verdict without a received frame");
    exact_hit_a: assert property (rx_frame.valid && s.rx_en[0] && !s.fifo_mode
        && s.mb_id[0] == rx_frame.id |=> result.store && result.index == '0)
        else $error("exact id match on mailbox 0 not stored");
    open_mask_a: assert property (rx_frame.valid && s.rx_en[0] && !s.mask_inval[0]
        && s.mask[0] == RST_WORD |=> result.store && result.index == '0)
        else $error("cleared mask did not accept on mailbox 0");
    ide_ignore_a: assert property (rx_frame.valid && s.rx_en[0] && !s.mask_inval[0]
        && s.fmt != FMT_MIXED && s.mask[0] == 32'h8000_0000 |=> result.store)
        else $error("ide compared outside mixed mode");
    rtr_cmp_a: assert property (rx_frame.valid && s.rx_en == MBS'(1) && !s.fifo_mode
        && !s.mask_inval[0] && s.mask[0] == 32'h4000_0000
        && rx_frame.id[RTR_BIT] != s.mb_id[0][RTR_BIT] |=> result.discard)
        else $error("remote bit mismatch accepted");
    fifo_mode_a: assert property (result.to_fifo |-> $past(s.fifo_mode))
        else $error("fifo store outside fifo mode");
    fifo_open_a: assert property (rx_frame.valid && s.fifo_mode && s.rx_en == '0
        && s.mask[FIFO_MK0] == RST_WORD |=> result.store && result.to_fifo)
        else $error("open fifo filter did not accept");

    // ****************************************
    // checks: bus side
    // ****************************************
    rdata_idle_a: assert property (!pready |-> prdata == RST_WORD)
        else $error("read data not zero outside an answer");

    err_ready_a: assert property (pslverr |-> pready)
        else $error("slave error without pready");

    unmapped_err_a: assert property (
        psel && penable && !pready && paddr == 12'h018 |=> pslverr && prdata == RST_WORD)
        else $error("unmapped access not refused");

    ctrl_read_a: assert property (
        psel && penable && !pready && !pwrite && paddr == OFF_CTRL
        |=> prdata[CTRL_FMT_LSB +: 2] == $past(s.fmt)
        && prdata[CTRL_FIFO_BIT] == $past(s.fifo_mode))
        else $error("control read lost a field");

    rxen_write_a: assert property (
        psel && penable && pready && pwrite && paddr == OFF_RXEN
        |=> s.rx_en == $past(pwdata[MBS-1:0]))
        else $error("receive enable write did not land");

    mask_write_a: assert property (
        psel && penable && pready && pwrite && paddr == OFF_MASK
        |=> s.mask[0] == ($past(pwdata) & LEGAL_BITS))
        else $error("mask write did not land");

    // ****************************************
    // checks: filter side
    // ****************************************
    fifo_index_a: assert property (
        result.to_fifo |-> result.store && result.index == IDX_W'(FIFO_BASE))
        else $error("fifo store with a wrong index");

    fifo_second_a: assert property (
        rx_frame.valid && s.fifo_mode && s.rx_en == '0 && s.mask[FIFO_MK1] == RST_WORD
        |=> result.store && result.to_fifo)
        else $error("open second fifo filter did not accept");

    fifo_exact_a: assert property (
        rx_frame.valid && s.fifo_mode && s.rx_en == '0 && rx_frame.id == s.fifo_cmp[0]
        |=> result.store && result.to_fifo)
        else $error("exact id on the first fifo filter not accepted");

    std_ext_skip_a: assert property (
        rx_frame.valid && s.rx_en[0] && !s.mask_inval[0] && !rx_frame.id[IDE_BIT]
        && s.mask[0] == EXT_BITS |=> result.store && result.index == '0)
        else $error("extended bits compared on a standard frame");

    inval_exact_a: assert property (
        rx_frame.valid && s.rx_en == MBS'(1) && !s.fifo_mode && s.mask_inval[0]
        && ((rx_frame.id ^ s.mb_id[0]) & 32'h5FFC_0000) != RST_WORD |=> result.discard)
        else $error("disabled mask did not compare every bit");

    masked_hit_a: assert property (
        rx_frame.valid && s.rx_en == MBS'(1) && !s.fifo_mode && !s.mask_inval[0]
        && !rx_frame.id[IDE_BIT] && !s.mb_id[0][IDE_BIT]
        && ((rx_frame.id ^ s.mb_id[0]) & s.mask[0] & LEGAL_BITS) == RST_WORD
        |=> result.store)
        else $error("masked-off bits still decided the frame");

    no_fifo_box_a: assert property (
        result.store && !result.to_fifo && $past(s.fifo_mode)
        |-> result.index < IDX_W'(FIFO_BASE))
        else $error("fifo mailbox matched a mailbox id in fifo mode");

    ide_mixed_a: assert property (
        rx_frame.valid && s.rx_en == MBS'(1) && !s.fifo_mode && s.fmt == FMT_MIXED
        && !s.mask_inval[0] && s.mask[0][IDE_BIT]
        && rx_frame.id[IDE_BIT] != s.mb_id[0][IDE_BIT] |=> result.discard)
        else $error("id extension bit ignored in mixed mode");

    ext_full_a: assert property (
        rx_frame.valid && s.rx_en == MBS'(1) && !s.fifo_mode && !s.mask_inval[0]
        && s.mask[0] == LEGAL_BITS && rx_frame.id[IDE_BIT]
        && (rx_frame.id & EXT_BITS) != (s.mb_id[0] & EXT_BITS) |=> result.discard)
        else $error("extended bits not compared under a full mask");
endmodule : caf_filter
`default_nettype wire

// File: testbench/caf_frame_src.sv
// frame source standing in for the remote nodes on the bus
`timescale 1ns/100ps
`default_nettype none
module caf_frame_src
    import caf_pkg::*;
(
    input  wire logic    pclk,
    output var  caf_rx_t rx_frame
);
    initial rx_frame = '{valid: 1'b0, id: 32'h0000_0000};
    // one frame per call; the id lines toggle once released, never hold
    task automatic send(input logic [31:0] id);
        @(posedge pclk);
        rx_frame <= '{valid: 1'b1, id: id};
        @(posedge pclk);
        rx_frame <= '{valid: 1'b0, id: ~id};
    endtask : send
endmodule : caf_frame_src
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the acceptance filter
`timescale 1ns/100ps
`default_nettype none
module tb_top import caf_pkg::*;;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    caf_rx_t     rx_frame;
    caf_res_t    result;
    logic [31:0] rd;
    logic        err;
    int          error_cnt = 0;
    int          n_checks  = 0;
    always #5 pclk = ~pclk;
    caf_filter caf_filter_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_frame(rx_frame), .result(result));
    caf_frame_src caf_frame_src_i (.pclk(pclk), .rx_frame(rx_frame));
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    // waits on pready with a bound, so a dead slave cannot hang the run
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int   n;
        logic got;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer looked at mid-cycle, where it has settled
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        got = pready;
        rd  = prdata;
        err = pslverr;
        // the write lands at this edge, so hold the request through it
        @(posedge pclk);
        check({31'b0, got}, 32'h0000_0001, "ready");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp, "read");
    endtask : rdchk
    // index is only meaningful on an accept
    task automatic frame(input logic [31:0] id, input logic st, input logic ff,
                         input logic [4:0] idx);
        caf_frame_src_i.send(id);
        #1;
        check({29'b0, result.store, result.discard, result.to_fifo}, {29'b0, st, ~st, ff}, "dec");
        if (st) check({27'b0, result.index}, {27'b0, idx}, "index");
    endtask : frame
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    // ****************************************
    // tests
    // ****************************************
    initial begin
        #100000;
        error_cnt++;
        $display("Error at %0t: watchdog", $time);
        finish_test();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFF_CTRL, RST_WORD);
        rdchk(OFF_MASK, RST_WORD);
        rdchk(OFF_MB, RST_WORD);
        apb(1'b0, 12'h018, 32'h0000_0000);
        check({31'b0, err}, 32'h0000_0001, "unmapped");
        $display("test reset done");
        apb(1'b1, OFF_CTRL, 32'h0000_0002);
        apb(1'b1, OFF_RXEN, 32'h0000_0001);
        apb(1'b1, OFF_MB, 32'h048C_0000);
        apb(1'b1, OFF_MASK, 32'hDFFC_0000);
        rdchk(OFF_MASK, 32'hDFFC_0000);
        frame(32'h048C_0000, 1'b1, 1'b0, 5'd0);
        frame(32'h448C_0000, 1'b0, 1'b0, 5'd0);
        frame(32'h0490_0000, 1'b0, 1'b0, 5'd0);
        apb(1'b1, OFF_MASK, 32'hDFF8_0000);
        frame(32'h0488_0000, 1'b1, 1'b0, 5'd0);
        frame(32'h048C_0000, 1'b1, 1'b0, 5'd0);
        frame(32'h0484_0000, 1'b0, 1'b0, 5'd0);
        apb(1'b1, OFF_MINV, 32'h0000_0001);
        frame(32'h0488_0000, 1'b0, 1'b0, 5'd0);
        apb(1'b1, OFF_MINV, 32'h0000_0000);
        $display("test standard done");
        apb(1'b1, OFF_MASK, 32'h0000_0000);
        frame(32'h0A00_0000, 1'b1, 1'b0, 5'd0);
        apb(1'b1, OFF_MASK, 32'h4000_0000);
        frame(32'h448C_0000, 1'b0, 1'b0, 5'd0);
        frame(32'h0A00_0000, 1'b1, 1'b0, 5'd0);
        apb(1'b1, OFF_MASK, 32'h0003_FFFF);
        frame(32'h048C_0001, 1'b1, 1'b0, 5'd0);
        frame(32'h848C_0001, 1'b0, 1'b0, 5'd0);
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        apb(1'b1, OFF_MASK, 32'h8000_0000);
        frame(32'h848C_0000, 1'b1, 1'b0, 5'd0);
        $display("test masks done");
        apb(1'b1, OFF_MASK, 32'hDFFC_0000);
        // stored id keeps its extension bit clear in every format
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, OFF_CTRL, f);
            frame(32'h848C_0000, f != 2, 1'b0, 5'd0);
        end
        $display("test format done");
        apb(1'b1, OFF_CTRL, 32'h0000_0002);
        apb(1'b1, OFF_MB, 32'h9234_5678);
        apb(1'b1, OFF_MASK, 32'hFFFF_FFFF);
        rdchk(OFF_MASK, 32'hDFFF_FFFF);
        frame(32'h9234_5678, 1'b1, 1'b0, 5'd0);
        frame(32'h9234_5679, 1'b0, 1'b0, 5'd0);
        frame(32'hD234_5678, 1'b0, 1'b0, 5'd0);
        $display("test extended done");
        apb(1'b1, OFF_RXEN, 32'h0000_0000);
        apb(1'b1, OFF_CTRL, 32'h0000_0006);
        apb(1'b1, OFF_FIFO0, 32'h048C_0000);
        apb(1'b1, OFF_FIFO1, 32'h0A00_0000);
        rdchk(OFF_FIFO0, 32'h048C_0000);
        frame(32'h0300_0000, 1'b1, 1'b1, 5'(FIFO_BASE));
        apb(1'b1, OFF_MASK + 12'h018, 32'hDFFC_0000);
        apb(1'b1, OFF_MASK + 12'h01C, 32'hDFF8_0000);
        frame(32'h048C_0000, 1'b1, 1'b1, 5'(FIFO_BASE));
        frame(32'h0488_0000, 1'b0, 1'b0, 5'd0);
        frame(32'h0A04_0000, 1'b1, 1'b1, 5'(FIFO_BASE));
        rdchk(OFF_STAT, 32'h0000_0318);
        frame(32'h0A08_0000, 1'b0, 1'b0, 5'd0);
        apb(1'b1, OFF_RXEN, 32'h0100_0001);
        frame(32'h9234_5678, 1'b1, 1'b0, 5'd0);
        frame(32'h0000_0000, 1'b0, 1'b0, 5'd0);
        apb(1'b1, OFF_CTRL, 32'h0000_0002);
        frame(32'h048C_0000, 1'b0, 1'b0, 5'd0);
        frame(32'h0000_0000, 1'b1, 1'b0, 5'd24);
        $display("test fifo done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
